/* File: pkg/wpm_pkg.sv */
package wpm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TARGET = 8'h04;
  localparam logic [7:0] OFF_WRAP_EN = 8'h08;
  localparam logic [7:0] OFF_RANGE = 8'h0c;
  localparam logic [7:0] OFF_OFFSET = 8'h10;
  localparam logic [7:0] OFF_WMODE = 8'h14;
  localparam logic [7:0] OFF_CMDPOS = 8'h18;
  localparam logic [7:0] OFF_ACTPOS = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_DELTA = 8'h24;
  localparam logic [7:0] OFF_RANGE_LO = 8'h28;

  // Control word bit positions
  localparam int BIT_NEW_SETPOINT = 4;
  localparam int BIT_ABS_REL = 6;
  localparam int BIT_REL_BASE = 12;
  localparam int BIT_PUSH = 13;
  localparam int BIT_WRAP = 14;

  // Scaling: range in 0.1 rev, offset in 0.01 percent
  localparam int STEPS_PER_REV = 10000;
  localparam int STEPS_PER_RANGE_UNIT = STEPS_PER_REV / 10;
  localparam int OFFSET_FULL_SCALE = 10000;

  // Reset values
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [31:0] RST_RANGE = 32'h0000000a;
  localparam logic [31:0] RST_OFFSET = 32'h00001388;
  localparam logic [1:0] RST_WMODE = 2'h0;

  // Wrap positioning mode selector values
  typedef enum logic [1:0] {
    WPM_ABS = 2'h0,
    WPM_NEAR = 2'h1,
    WPM_FWD = 2'h2,
    WPM_REV = 2'h3
  } wpm_mode_t;

  // Move computation states, Gray order
  typedef enum logic [1:0] {
    WPM_IDLE = 2'b00,
    WPM_CALC = 2'b01,
    WPM_FOLD = 2'b11,
    WPM_DONE = 2'b10
  } wpm_state_t;

endpackage

/* File: hdl/wpm_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a level from outside the clock domain
module wpm_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);

  logic meta_q;

  ////////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* File: hdl/wpm_fold.sv */
`timescale 1ns/1ps
// Folds a position into [lo, lo+span) when span is positive, else passes it through; combinational
module wpm_fold
(
  input wire logic signed [31:0] pos,
  input wire logic signed [31:0] lo,
  input wire logic signed [31:0] span,
  output logic signed [31:0] folded
);

  logic signed [31:0] rel;
  logic signed [31:0] m;

  ////////////////////////////////////////////////////////////////////////////
  // Signed modulo corrected to a non-negative remainder
  always_comb
  begin
    rel = pos - lo;
    if (span > 32'sd0)
    begin
      m = rel % span;
      if (m < 32'sd0)
        m = m + span;
      folded = lo + m;
    end
    else
    begin
      m = 32'sd0;
      folded = pos;
    end
  end

endmodule

/* File: hdl/wpm_top.sv */
`timescale 1ns/1ps
module wpm_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] act_pos_in,
  input wire logic act_valid_in,
  output logic move_start,
  output logic move_dir_fwd,
  output logic move_push,
  output logic signed [31:0] move_delta
);

  logic [15:0] ctrl_q;
  logic signed [31:0] target_q;
  logic wrap_en_q;
  logic [31:0] range_q;
  logic [31:0] offset_q;
  logic [1:0] wmode_q;
  logic signed [31:0] cmd_pos_q;
  logic signed [31:0] act_pos_q;
  logic act_valid_s;
  logic setpoint_prev_q;
  logic busy_q;
  logic err_q;
  logic wrap_move_q;
  logic signed [31:0] delta_q;
  logic signed [31:0] dest_q;
  logic signed [31:0] span_q;
  logic signed [31:0] lo_q;
  logic signed [31:0] fold_out;
  logic signed [31:0] fold_in;
  logic signed [31:0] fold_cmd;
  logic signed [31:0] cur_fold;
  logic signed [31:0] fwd_d;
  logic signed [31:0] span_d;
  logic signed [31:0] lo_d;
  logic signed [63:0] lo_wide;
  logic wr_en;
  logic rd_en;
  logic setpoint_rise;
  wpm_pkg::wpm_state_t state_q;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign setpoint_rise = ctrl_q[wpm_pkg::BIT_NEW_SETPOINT] && !setpoint_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Actual position is sampled only when its strobe is synchronised
  wpm_sync u_act_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .d(act_valid_in),
    .q(act_valid_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Range span and lower bound from scaled settings
  always_comb
  begin
    span_d = 32'(range_q * 32'(wpm_pkg::STEPS_PER_RANGE_UNIT));
    // Signed product, so the division below rounds a negative bound
    lo_wide = -(64'(span_d) * $signed(64'(offset_q)));
    lo_d = 32'(lo_wide / 64'(wpm_pkg::OFFSET_FULL_SCALE));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared folding unit: target in CALC, command position otherwise
  assign fold_in = (state_q == wpm_pkg::WPM_CALC) ? target_q : cmd_pos_q;

  wpm_fold u_fold
  (
    .pos(fold_in),
    .lo(lo_q),
    .span(span_q),
    .folded(fold_out)
  );

  wpm_fold u_fold_cmd
  (
    .pos(dest_q),
    .lo(lo_q),
    .span(span_q),
    .folded(fold_cmd)
  );

  // Plain moves may leave the position outside the range; fold it too
  wpm_fold u_fold_cur
  (
    .pos(cmd_pos_q),
    .lo(lo_q),
    .span(span_q),
    .folded(cur_fold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Forward distance from folded command position to folded target
  always_comb
  begin
    fwd_d = fold_out - cur_fold;
    if (fwd_d < 32'sd0)
      fwd_d = fwd_d + span_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; held only on APB access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= wpm_pkg::RST_CTRL;
      target_q <= 32'sd0;
      wrap_en_q <= 1'b0;
      range_q <= wpm_pkg::RST_RANGE;
      offset_q <= wpm_pkg::RST_OFFSET;
      wmode_q <= wpm_pkg::RST_WMODE;
    end
    else if (wr_en)
    begin
      case (paddr)
        wpm_pkg::OFF_CTRL: ctrl_q <= pwdata[15:0];
        wpm_pkg::OFF_TARGET: target_q <= pwdata;
        wpm_pkg::OFF_WRAP_EN: wrap_en_q <= pwdata[0];
        wpm_pkg::OFF_RANGE: range_q <= pwdata;
        wpm_pkg::OFF_OFFSET: offset_q <= pwdata;
        wpm_pkg::OFF_WMODE: wmode_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Actual position capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_pos_q <= 32'sd0;
    else if (act_valid_s)
      act_pos_q <= act_pos_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Move sequencer; edge of new-setpoint bit starts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= wpm_pkg::WPM_IDLE;
      setpoint_prev_q <= 1'b0;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      wrap_move_q <= 1'b0;
      span_q <= 32'sd0;
      lo_q <= 32'sd0;
    end
    else
    begin
      setpoint_prev_q <= ctrl_q[wpm_pkg::BIT_NEW_SETPOINT];
      case (state_q)
        wpm_pkg::WPM_IDLE:
        begin
          busy_q <= 1'b0;
          if (setpoint_rise)
          begin
            wrap_move_q <= ctrl_q[wpm_pkg::BIT_WRAP];
            // Wrap without enable or zero span is refused
            if (ctrl_q[wpm_pkg::BIT_WRAP] && (!wrap_en_q || span_d <= 0))
              err_q <= 1'b1;
            else
            begin
              err_q <= 1'b0;
              busy_q <= 1'b1;
              span_q <= span_d;
              lo_q <= lo_d;
              state_q <= wpm_pkg::WPM_CALC;
            end
          end
        end
        wpm_pkg::WPM_CALC: state_q <= wpm_pkg::WPM_FOLD;
        wpm_pkg::WPM_FOLD: state_q <= wpm_pkg::WPM_DONE;
        wpm_pkg::WPM_DONE: state_q <= wpm_pkg::WPM_IDLE;
        default: state_q <= wpm_pkg::WPM_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Travel computation per mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      delta_q <= 32'sd0;
      dest_q <= 32'sd0;
    end
    else if (state_q == wpm_pkg::WPM_CALC)
    begin
      if (wrap_move_q)
      begin
        // Abs/Rel bit is deliberately not looked at here
        case (wpm_pkg::wpm_mode_t'(wmode_q))
          wpm_pkg::WPM_ABS:
            delta_q <= fold_out - cur_fold;
          wpm_pkg::WPM_NEAR:
            if (fwd_d > (span_q >>> 1))
              delta_q <= fwd_d - span_q;
            else
              delta_q <= fwd_d;
          wpm_pkg::WPM_FWD:
            delta_q <= (fwd_d == 0) ? 32'sd0 : fwd_d;
          wpm_pkg::WPM_REV:
            delta_q <= (fwd_d == 0) ? 32'sd0 : fwd_d - span_q;
          default: delta_q <= 32'sd0;
        endcase
        dest_q <= fold_out;
      end
      else if (ctrl_q[wpm_pkg::BIT_ABS_REL])
      begin
        // Base is actual position when bit 12 is set
        if (ctrl_q[wpm_pkg::BIT_REL_BASE])
        begin
          delta_q <= act_pos_q + target_q - cmd_pos_q;
          dest_q <= act_pos_q + target_q;
        end
        else
        begin
          delta_q <= target_q;
          dest_q <= cmd_pos_q + target_q;
        end
      end
      else
      begin
        delta_q <= target_q - cmd_pos_q;
        dest_q <= target_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command position update; wrap moves are folded into the range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_pos_q <= 32'sd0;
    else if (state_q == wpm_pkg::WPM_FOLD)
      cmd_pos_q <= wrap_move_q ? fold_cmd : dest_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Move outputs, one-cycle start pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      move_start <= 1'b0;
      move_dir_fwd <= 1'b1;
      move_push <= 1'b0;
      move_delta <= 32'sd0;
    end
    else
    begin
      move_start <= (state_q == wpm_pkg::WPM_FOLD);
      if (state_q == wpm_pkg::WPM_FOLD)
      begin
        move_delta <= delta_q;
        move_dir_fwd <= (delta_q >= 0);
        move_push <= ctrl_q[wpm_pkg::BIT_PUSH];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path; zero wait states, unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable)
      begin
        case (paddr)
          wpm_pkg::OFF_CTRL: prdata <= {16'h0000, ctrl_q};
          wpm_pkg::OFF_TARGET: prdata <= target_q;
          wpm_pkg::OFF_WRAP_EN: prdata <= {31'h00000000, wrap_en_q};
          wpm_pkg::OFF_RANGE: prdata <= range_q;
          wpm_pkg::OFF_OFFSET: prdata <= offset_q;
          wpm_pkg::OFF_WMODE: prdata <= {30'h00000000, wmode_q};
          wpm_pkg::OFF_CMDPOS: prdata <= cmd_pos_q;
          wpm_pkg::OFF_ACTPOS: prdata <= act_pos_q;
          wpm_pkg::OFF_STATUS: prdata <= {30'h00000000, err_q, busy_q};
          wpm_pkg::OFF_DELTA: prdata <= delta_q;
          wpm_pkg::OFF_RANGE_LO: prdata <= lo_d;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

/* File: test/wpm_top_asserts.sv */
`timescale 1ns/1ps
// Port-level checks of the wrap positioning block
module wpm_top_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] act_pos_in,
  input wire logic act_valid_in,
  input wire logic move_start,
  input wire logic move_dir_fwd,
  input wire logic move_push,
  input wire logic signed [31:0] move_delta
);
  logic [3:0] age_q;
  logic ctl_wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Age of last control write, saturating so it never wraps into range
  assign ctl_wr = psel && penable && pready && pwrite &&
    paddr == wpm_pkg::OFF_CTRL;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_q <= 4'hf;
    else if (ctl_wr)
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_zero_wait;
    s_setup |=> s_access;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("access phase without ready");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held too long");
  property p_ready_phase;
    pready |-> psel && penable;
  endproperty
  a_ready_phase: assert property (p_ready_phase)
    else $error("ready outside access");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_unmapped;
    pready && paddr > 8'h28 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access accepted");
  ////////////////////////////////////////////////////////////////////////////
  // Move issue
  property p_start_pulse;
    move_start |=> !move_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_start_cause;
    move_start |-> age_q inside {[4'h2:4'h6]};
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without recent control write");
  property p_dir;
    move_start |-> move_dir_fwd == !move_delta[31];
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction disagrees with travel");
  property p_hold;
    $changed(move_delta) |-> move_start;
  endproperty
  a_hold: assert property (p_hold)
    else $error("travel changed without a move");
endmodule

bind wpm_top wpm_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .act_pos_in(act_pos_in), .act_valid_in(act_valid_in),
  .move_start(move_start), .move_dir_fwd(move_dir_fwd),
  .move_push(move_push), .move_delta(move_delta));

/* File: test/wpm_mst.sv */
`timescale 1ns/1ps
// Bus master standing in for the fieldbus controller
module wpm_mst
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  logic err;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err = 1'b0;
  end
  // One transfer; an edge passes first so release and setup never collide
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that is never answered
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: test/test_wpm_top.sv */
`timescale 1ns/1ps
module test_wpm_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] act_pos_in = 32'd900;
  logic act_valid_in = 1'b0;
  logic move_start, move_dir_fwd, move_push;
  logic signed [31:0] move_delta;
  int error_cnt = 0;
  int n_tests = 0;
  always #20 pclk = ~pclk;
  wpm_mst i_mst (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  wpm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .act_pos_in(act_pos_in), .act_valid_in(act_valid_in),
    .move_start(move_start), .move_dir_fwd(move_dir_fwd),
    .move_push(move_push), .move_delta(move_delta));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_mst.xfer(1'b1, a, d, rd);
  endtask
  // Clear the setpoint bit, then raise it; judge issue and new position
  task automatic move(input logic [15:0] c, input logic [31:0] t,
    input logic [31:0] dl, input logic [31:0] pos);
    int n;
    wr(wpm_pkg::OFF_TARGET, t);
    wr(wpm_pkg::OFF_CTRL, {16'h0, c});
    wr(wpm_pkg::OFF_CTRL, {16'h0, c | 16'h0010});
    n = 0;
    while (move_start !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, move_start}, 32'h1);
    chk(move_delta, dl);
    chk({31'h0, move_dir_fwd}, {31'h0, ~dl[31]});
    chk({31'h0, move_push}, {31'h0, c[13]});
    i_mst.xfer(1'b0, wpm_pkg::OFF_CMDPOS, 32'h0, rd);
    chk(rd, pos);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    i_mst.xfer(1'b0, wpm_pkg::OFF_RANGE, 32'h0, rd);
    chk(rd, 32'h0000000a);
    i_mst.xfer(1'b0, wpm_pkg::OFF_OFFSET, 32'h0, rd);
    chk(rd, 32'h00001388);
    i_mst.xfer(1'b0, wpm_pkg::OFF_RANGE_LO, 32'h0, rd);
    chk(rd, -32'sd5000);
    i_mst.xfer(1'b1, 8'h2c, 32'h1, rd);
    chk({31'h0, i_mst.err}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_plain();
    move(16'h0000, 32'd1000, 32'd1000, 32'd1000);
    move(16'h0040, 32'd3000, 32'd3000, 32'd4000);
    // Strobe passes two flops before the position is taken
    act_valid_in <= 1'b1;
    repeat (3) @(posedge pclk);
    i_mst.xfer(1'b0, wpm_pkg::OFF_ACTPOS, 32'h0, rd);
    chk(rd, 32'd900);
    move(16'h1040, 32'd3000, -32'sd100, 32'd3900);
    move(16'h2000, 32'd1000, -32'sd2900, 32'd1000);
    $display("test plain done");
  endtask
  // Wrap requested while disabled must be refused
  task automatic t_refuse();
    int n;
    wr(wpm_pkg::OFF_CTRL, 32'h4000);
    wr(wpm_pkg::OFF_CTRL, 32'h4010);
    n = 0;
    repeat (8)
    begin
      @(posedge pclk);
      n += move_start === 1'b1;
    end
    chk(n, 0);
    i_mst.xfer(1'b0, wpm_pkg::OFF_STATUS, 32'h0, rd);
    chk({31'h0, rd[1]}, 32'h1);
    $display("test refuse done");
  endtask
  // Targets stay inside the range; abs/rel bit set to show it is ignored
  task automatic t_wrap();
    logic [31:0] tg[4] = '{-32'sd4000, 32'd4000, 32'd4500, -32'sd4500};
    logic [31:0] dl[4] = '{32'd5000, -32'sd2000, -32'sd9500, -32'sd9000};
    logic [1:0] md[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    wr(wpm_pkg::OFF_WRAP_EN, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(wpm_pkg::OFF_WMODE, {30'h0, md[i]});
      move(16'h4040, tg[i], dl[i], tg[i]);
    end
    // Plain move ends outside the range; next wrap move must fold it
    move(16'h0000, 32'd7000, 32'd11500, 32'd7000);
    wr(wpm_pkg::OFF_WMODE, 32'h2);
    move(16'h4040, -32'sd4000, 32'd9000, -32'sd4000);
    $display("test wrap done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run is a few hundred cycles
  initial
  begin
    #400000;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_plain();
    t_refuse();
    t_wrap();
    results();
  end
endmodule
